// ---- vsv_host_model.sv ----
module vsv_host_model
(
  input wire logic mclk,
  output logic [7:0] cmd_code,
  output logic rd_req,
  output logic wr_req,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic cmd_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_code = 8'h00;
    rd_req = 1'b0;
    wr_req = 1'b0;
    wr_data = 8'h00;
  end
  // One byte per call; answer sampled at the falling edge after the taking edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] q, output logic v, output logic r);
    @(negedge mclk);
    cmd_code = c;
    wr_data = d;
    rd_req = !w;
    wr_req = w;
    @(negedge mclk);
    rd_req = 1'b0;
    wr_req = 1'b0;
    cmd_code = ~c;
    wr_data = ~d;
    q = rd_data;
    v = rd_valid;
    r = cmd_refused;
  endtask
endmodule

// ---- vsv_pkg.sv ----
package vsv_pkg;
  localparam logic [7:0] CMD_STATUS = 8'h80;
  localparam logic [7:0] CMD_VIN = 8'h88;
  localparam logic [7:0] CMD_GLOBAL_CLEAR = 8'h03;
  localparam int BIT_DISC_MODE = 7;
  localparam int BIT_CTRL_OT = 6;
  localparam int BIT_STAGE_FAULT = 5;
  localparam int BIT_LINK_ERR = 4;
  localparam int BIT_RESTORE_ERR = 3;
  localparam int BIT_NEG_OC = 2;
  localparam int BIT_STAGE_OT = 1;
  localparam int BIT_GATE_UV = 0;
  localparam logic [7:0] STICKY_MASK = 8'h7d;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] VIN_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 40;
  localparam int VIN_REFRESH_US = 190;
  localparam int VIN_REFRESH_CYCLES = (VIN_REFRESH_US * 1000) / CLK_PERIOD_NS;
endpackage

// ---- vsv_status.sv ----
module vsv_status
#(
  parameter int VIN_REFRESH = vsv_pkg::VIN_REFRESH_CYCLES
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] cmd_code,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic cmd_refused,
  input wire logic discontinuous_mode_flag,
  input wire logic ctrl_die_ot_trip,
  input wire logic stage_die_ot_trip,
  input wire logic stage_fault_evt,
  input wire logic interdie_link_err,
  input wire logic nvm_restore_done,
  input wire logic nvm_restore_fail,
  input wire logic neg_oc_cycle_evt,
  input wire logic gate_drive_uv,
  input wire logic [7:0] vin_meas,
  output logic [7:0] input_voltage_reading,
  output logic vin_refresh
);
  import vsv_pkg::*;

  // Refuse a refresh period the counter cannot serve
  if (VIN_REFRESH < 1)
  begin
    $error("VIN_REFRESH must be at least 1");
  end

  typedef struct packed {
    logic [7:0] sticky;
    logic init_done;
    logic [7:0] rd_data;
    logic rd_valid;
    logic refused;
  } vsv_state_t;

  vsv_state_t st_q;
  vsv_state_t st_d;

  logic [7:0] vin_q;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] status_view;
  logic wr_status;
  logic wr_clear;

  function automatic logic [7:0] sticky_next(input logic [7:0] q, input logic [7:0] clr,
                                             input logic [7:0] set);
    sticky_next = ((q & ~clr) | set) & STICKY_MASK;
  endfunction

  vsv_vin_sampler #(
    .REFRESH_CYCLES(VIN_REFRESH)
  ) u_vin (
    .mclk(mclk),
    .rstn(rstn),
    .vin_meas(vin_meas),
    .vin_q(vin_q),
    .refresh(vin_refresh)
  );

  assign wr_status = wr_req && (cmd_code == CMD_STATUS);
  assign wr_clear = wr_req && (cmd_code == CMD_GLOBAL_CLEAR);

  // Fault events that raise sticky bits
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[BIT_CTRL_OT] = ctrl_die_ot_trip;
    set_vec[BIT_STAGE_FAULT] = stage_fault_evt;
    set_vec[BIT_LINK_ERR] = interdie_link_err;
    set_vec[BIT_RESTORE_ERR] = nvm_restore_done && nvm_restore_fail && !st_q.init_done;
    set_vec[BIT_NEG_OC] = neg_oc_cycle_evt;
    set_vec[BIT_GATE_UV] = gate_drive_uv;
  end

  // Write-one clear or global clear, live bits masked off
  always_comb
  begin
    clr_vec = 8'h00;
    if (wr_clear)
    begin
      clr_vec = STICKY_MASK;
    end
    else if (wr_status)
    begin
      clr_vec = wr_data & STICKY_MASK;
    end
  end

  // Live bits read straight from their detectors
  always_comb
  begin
    status_view = st_q.sticky;
    status_view[BIT_DISC_MODE] = discontinuous_mode_flag;
    status_view[BIT_STAGE_OT] = stage_die_ot_trip;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.rd_valid = 1'b0;
    st_d.refused = 1'b0;
    st_d.sticky = sticky_next(st_q.sticky, clr_vec, set_vec);
    st_d.init_done = st_q.init_done | nvm_restore_done;
    if (rd_req)
    begin
      st_d.rd_valid = 1'b1;
      unique case (cmd_code)
        CMD_STATUS: st_d.rd_data = status_view;
        CMD_VIN: st_d.rd_data = vin_q;
        default:
        begin
          st_d.rd_data = 8'h00;
          st_d.refused = 1'b1;
        end
      endcase
    end
    else if (wr_req && !wr_status && !wr_clear)
    begin
      st_d.refused = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '{sticky: STATUS_RESET, init_done: 1'b0, rd_data: 8'h00,
                rd_valid: 1'b0, refused: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd_data;
  assign rd_valid = st_q.rd_valid;
  assign cmd_refused = st_q.refused;
  assign input_voltage_reading = vin_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Command port, status bit and input voltage checks
  logic rd_status;
  logic rd_vin;
  logic wr_other;
  assign rd_status = rd_req && (cmd_code == CMD_STATUS);
  assign rd_vin = rd_req && (cmd_code == CMD_VIN);
  assign wr_other = wr_req && !wr_status && !wr_clear;

  a_mode_live_copy: assert property (rd_status
                                     |=> rd_data[BIT_DISC_MODE] == $past(discontinuous_mode_flag))
    else $error("Mode bit not live");
  a_cont_reads_zero: assert property (rd_status && !discontinuous_mode_flag
                                      |=> rd_valid && !rd_data[BIT_DISC_MODE])
    else $error("Continuous mode not read as zero");
  a_ctrl_ot_latch: assert property (ctrl_die_ot_trip |=> st_q.sticky[BIT_CTRL_OT] [*1])
    else $error("Controller overtemperature not latched");
  a_stage_ot_live: assert property (rd_status
                                    |=> rd_data[BIT_STAGE_OT] == $past(stage_die_ot_trip))
    else $error("Stage overtemperature bit not live");
  a_stage_fault_latch: assert property (stage_fault_evt |=> st_q.sticky[BIT_STAGE_FAULT])
    else $error("Stage fault not latched");
  a_link_err_latch: assert property (interdie_link_err |=> st_q.sticky[BIT_LINK_ERR])
    else $error("Link error not latched");
  a_restore_err_set: assert property (nvm_restore_done && nvm_restore_fail && !st_q.init_done
                                      |=> st_q.sticky[BIT_RESTORE_ERR] && st_q.init_done)
    else $error("Initial restore failure not latched");
  a_restore_later_quiet: assert property (st_q.init_done && !st_q.sticky[BIT_RESTORE_ERR]
                                          |=> !st_q.sticky[BIT_RESTORE_ERR])
    else $error("Restore error set after initial restore");
  a_neg_oc_latch: assert property (neg_oc_cycle_evt |=> st_q.sticky[BIT_NEG_OC])
    else $error("Negative overcurrent not latched");
  a_gate_uv_latch: assert property (gate_drive_uv |=> st_q.sticky[BIT_GATE_UV])
    else $error("Gate drive undervoltage not latched");
  a_vin_read_value: assert property (rd_vin
                                     |=> rd_valid && !cmd_refused && rd_data == $past(vin_q))
    else $error("Input voltage read wrong");
  a_vin_write_refused: assert property (wr_req && cmd_code == CMD_VIN && !rd_req
                                        |=> cmd_refused)
    else $error("Write to input voltage not refused");
  a_global_clear_works: assert property (wr_clear && !rd_req && set_vec == 8'h00
                                         |=> st_q.sticky == 8'h00)
    else $error("Global clear failed");
  a_w1c_clears_bit: assert property (wr_status && wr_data[BIT_NEG_OC] && !neg_oc_cycle_evt
                                     |=> !st_q.sticky[BIT_NEG_OC])
    else $error("Write-one clear failed");
  a_set_beats_clear: assert property (wr_clear && ctrl_die_ot_trip
                                      |=> st_q.sticky[BIT_CTRL_OT])
    else $error("Persisting condition lost on clear");
  a_sticky_holds: assert property (st_q.sticky[BIT_STAGE_FAULT] && !wr_clear
                                   && !(wr_status && wr_data[BIT_STAGE_FAULT])
                                   |=> st_q.sticky[BIT_STAGE_FAULT])
    else $error("Sticky bit dropped without clear");
  a_unmapped_refused: assert property (rd_req && !rd_status && !rd_vin
                                       |=> rd_valid && cmd_refused && rd_data == 8'h00)
    else $error("Unmapped read not refused");
  a_valid_after_req: assert property (rd_valid |-> $past(rd_req))
    else $error("Read answer without request");
  a_write_refused: assert property (wr_other && !rd_req |=> cmd_refused && !rd_valid)
    else $error("Unsupported write not refused");
  a_refused_no_effect: assert property (wr_other && set_vec == 8'h00
                                        |=> st_q.sticky == $past(st_q.sticky))
    else $error("Refused write changed status");
  a_restore_err_source: assert property (!st_q.sticky[BIT_RESTORE_ERR]
                                         && !(nvm_restore_done && nvm_restore_fail)
                                         |=> !st_q.sticky[BIT_RESTORE_ERR])
    else $error("Restore error set without failed restore");
  a_vin_holds: assert property (!vin_refresh |-> $stable(input_voltage_reading))
    else $error("Input voltage changed between refreshes");

  // Main scenarios reached
  c_mode_read_one: cover property (rd_status && discontinuous_mode_flag
                                   ##1 rd_data[BIT_DISC_MODE]);
  c_clear_then_reset: cover property (st_q.sticky[BIT_GATE_UV] ##1 wr_status ##1 !st_q.sticky[0]);
  c_vin_refresh_read: cover property (vin_refresh ##1 rd_vin ##1 rd_valid);
  c_restore_error: cover property (st_q.sticky[BIT_RESTORE_ERR]);
  c_global_clear: cover property (wr_clear ##1 st_q.sticky == 8'h00);
endmodule

// ---- vsv_status_tb_top.sv ----
module vsv_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vsv_pkg::*;
  localparam int REF = 8;
  logic mclk, rstn, rd_req, wr_req, rd_valid, cmd_refused, done, fail, vin_refresh;
  logic [7:0] cmd_code, wr_data, rd_data, vin_meas, vin_rd, flt;
  logic [7:0] stk [5] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h01};
  int n_errors, checks, n;
  vsv_status #(.VIN_REFRESH(REF)) uut (.mclk(mclk), .rstn(rstn), .cmd_code(cmd_code),
    .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_refused(cmd_refused), .discontinuous_mode_flag(flt[7]),
    .ctrl_die_ot_trip(flt[6]), .stage_die_ot_trip(flt[1]), .stage_fault_evt(flt[5]),
    .interdie_link_err(flt[4]), .nvm_restore_done(done), .nvm_restore_fail(fail),
    .neg_oc_cycle_evt(flt[2]), .gate_drive_uv(flt[0]), .vin_meas(vin_meas),
    .input_voltage_reading(vin_rd), .vin_refresh(vin_refresh));
  vsv_host_model host (.mclk(mclk), .cmd_code(cmd_code), .rd_req(rd_req), .wr_req(wr_req),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_refused(cmd_refused));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp, input logic rf);
    logic [7:0] q;
    logic v, r;
    host.xfer(1'b0, c, 8'h00, q, v, r);
    chk(q, exp);
    chk({v, r}, {1'b1, rf});
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic rf);
    logic [7:0] q;
    logic v, r;
    host.xfer(1'b1, c, d, q, v, r);
    chk({7'h00, r}, {7'h00, rf});
  endtask
  task automatic wait_ref();
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (vin_refresh !== 1'b1 && n < 4 * REF);
    if (vin_refresh !== 1'b1)
    begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic restore_pulse();
    @(negedge mclk);
    done = 1'b1;
    fail = 1'b1;
    @(negedge mclk);
    done = 1'b0;
    fail = 1'b0;
  endtask
  initial
  begin
    rstn = 1'b0;
    flt = 8'h00;
    done = 1'b0;
    fail = 1'b0;
    vin_meas = 8'h00;
    n_errors = 0;
    checks = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    rd(CMD_STATUS, STATUS_RESET, 1'b0);
    rd(CMD_VIN, VIN_RESET, 1'b0);
    restore_pulse();
    rd(CMD_STATUS, 8'h08, 1'b0);
    wr(CMD_STATUS, 8'h08, 1'b0);
    rd(CMD_STATUS, 8'h00, 1'b0);
    restore_pulse();
    rd(CMD_STATUS, 8'h00, 1'b0);
    flt = 8'h82;
    rd(CMD_STATUS, 8'h82, 1'b0);
    wr(CMD_GLOBAL_CLEAR, 8'h00, 1'b0);
    wr(CMD_STATUS, 8'h82, 1'b0);
    rd(CMD_STATUS, 8'h82, 1'b0);
    flt = 8'h00;
    rd(CMD_STATUS, 8'h00, 1'b0);
    foreach (stk[i])
    begin
      @(negedge mclk);
      flt = stk[i];
      @(negedge mclk);
      flt = 8'h00;
      rd(CMD_STATUS, stk[i], 1'b0);
      rd(CMD_STATUS, stk[i], 1'b0);
      wr(CMD_STATUS, stk[i], 1'b0);
      rd(CMD_STATUS, 8'h00, 1'b0);
    end
    flt = 8'h40;
    wr(CMD_GLOBAL_CLEAR, 8'h00, 1'b0);
    rd(CMD_STATUS, 8'h40, 1'b0);
    flt = 8'h00;
    wr(CMD_GLOBAL_CLEAR, 8'h00, 1'b0);
    rd(CMD_STATUS, 8'h00, 1'b0);
    vin_meas = 8'h5a;
    wait_ref();
    chk(vin_rd, 8'h5a);
    rd(CMD_VIN, 8'h5a, 1'b0);
    wr(CMD_VIN, 8'hff, 1'b1);
    rd(CMD_VIN, 8'h5a, 1'b0);
    wait_ref();
    vin_meas = 8'h3c;
    rd(CMD_VIN, 8'h5a, 1'b0);
    wait_ref();
    chk(8'(n), 8'(REF - 2));
    rd(CMD_VIN, 8'h3c, 1'b0);
    flt = 8'h01;
    rd(CMD_STATUS, 8'h01, 1'b0);
    flt = 8'h00;
    rstn = 1'b0;
    @(negedge mclk);
    chk(rd_data, 8'h00);
    chk(vin_rd, VIN_RESET);
    rstn = 1'b1;
    rd(CMD_STATUS, STATUS_RESET, 1'b0);
    restore_pulse();
    rd(CMD_STATUS, 8'h08, 1'b0);
    rd(8'h42, 8'h00, 1'b1);
    wrap_up();
  end
endmodule

// ---- vsv_vin_sampler.sv ----
module vsv_vin_sampler
#(
  parameter int REFRESH_CYCLES = vsv_pkg::VIN_REFRESH_CYCLES
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] vin_meas,
  output logic [7:0] vin_q,
  output logic refresh
);
  import vsv_pkg::*;

  localparam int CW = $clog2(REFRESH_CYCLES + 1);

  if (REFRESH_CYCLES < 1)
  begin
    $error("REFRESH_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [7:0] val;
    logic pulse;
  } vsv_smp_t;

  vsv_smp_t s_q;
  vsv_smp_t s_d;

  // Capture the measurement once per refresh period
  always_comb
  begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (s_q.cnt == CW'(REFRESH_CYCLES - 1))
    begin
      s_d.cnt = '0;
      s_d.val = vin_meas;
      s_d.pulse = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '{cnt: '0, val: VIN_RESET, pulse: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign vin_q = s_q.val;
  assign refresh = s_q.pulse;
endmodule
